// ==== src/rcw_regs.vh ====
// Register offsets, field positions and reset values of the clock config window block
`ifndef RCW_REGS_VH
`define RCW_REGS_VH

// Byte addresses on the register bus
`define RCW_CFG_OFS      8'h00
`define RCW_VALH_OFS     8'h04
`define RCW_VALL_OFS     8'h08
`define RCW_TIME_OFS     8'h0C

// Configuration field positions
`define RCW_EN_BIT       15
`define RCW_WREN_BIT     13
`define RCW_SYNC_BIT     12
`define RCW_HALF_BIT     11
`define RCW_OE_BIT       10
`define RCW_PTR_HI       9
`define RCW_PTR_LO       8

// Reset values
`define RCW_CFG_RST      16'h0000
`define RCW_FIELD_RST    8'h00
`define RCW_PTR_RST      2'b00

// Pointer codes
`define RCW_PTR_0        2'b00
`define RCW_PTR_1        2'b01
`define RCW_PTR_2        2'b10
`define RCW_PTR_3        2'b11

`endif

// ==== src/rcw_top.v ====
// Configuration, status and value-window pointer logic of a real-time clock
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "rcw_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview
//
// One configuration word sits at the bottom of the map. It holds the module
// enable, the write lock of the value windows, two hardware status bits, the
// output enable, the window pointer and an eight bit trim value.
//
// Two byte-wide windows, high and low, look into a small store of time
// fields. The pointer picks the field pair; every access of the high window
// steps the pointer down toward zero, so software can walk the fields with
// a run of low-then-high accesses after loading the pointer once.
//
// A fourth word returns the minutes/seconds pair together, read only.
//
// Bus timing
//
// Writes complete with no wait state: the store is updated at the edge that
// ends the data phase, using the write data that stands in that phase.
//
// Reads insert one wait state. The read word is registered, so the data
// phase is stretched by one cycle and the word stands on the bus while
// ready is high again. The pointer step of a high window read happens at
// the very end of the data phase, after the word has been captured, so the
// value returned always belongs to the pointer seen at the start.
//
// Side effects of an access are gated by the bus ready, so a stretched
// data phase steps the pointer once and not once per cycle.
//
// Clock enable
//
// While the clock enable is low every flop but the two reset release flops holds, the bus included. A
// master that sees ready low simply waits; nothing is lost.
//
// Reset
//
// Only the power-on reset reaches the configuration word. It is applied at
// once and released through two flops, so all logic leaves reset together
// on a clock edge and never sees a release that races the clock.
//
// Status inputs
//
// The ripple and half-second inputs come from the counting logic, which
// may run from another clock, so both pass two flops before use.
//
// Limitations
//
// Only the low address byte is decoded: the map repeats every 256 bytes.
// The trim value is stored and shown but not applied here.
////////////////////////////////////////////////////////////////////////////////

module rcw_top (
   input  wire        clock,
   input  wire        resetn,          // Power-on reset, active low
   input  wire        clk_en,          // Freezes all state but the reset release flops when low
   input  wire        ripple_pin,      // Rollover ripple in progress, async
   input  wire        half_sec_pin,    // Second half of the second, async
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output reg         module_enable,   // Calendar module running
   output reg         clock_out_en,    // Clock output pin driven
   output reg  [7:0]  calibration      // Trim value toward the counter
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers
   reg        rst_s1_r;                // First reset stage
   reg        rst_s2_r;                // Reset used by the design
   reg        rip_s1_r;                // Ripple first stage
   reg        rip_s2_r;                // Ripple usable copy
   reg        hs_s1_r;                 // Half-second first stage
   reg        hs_s2_r;                 // Half-second usable copy
   reg        hs_d_r;                  // Previous half-second level

   // Assert at once, release after two edges
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   // Two flops before any logic sees the pins
   always @(posedge clock or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         rip_s1_r <= 1'b0;
         rip_s2_r <= 1'b0;
         hs_s1_r  <= 1'b0;
         hs_s2_r  <= 1'b0;
         hs_d_r   <= 1'b0;
      end else if (clk_en) begin
         rip_s1_r <= ripple_pin;
         rip_s2_r <= rip_s1_r;
         hs_s1_r  <= half_sec_pin;
         hs_s2_r  <= hs_s1_r;
         hs_d_r   <= hs_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   reg        ph_act_r;                // Data phase pending
   reg        ph_wr_r;                 // Pending access is a write
   reg [7:0]  ph_addr_r;               // Pending byte address
   wire       take = hsel & htrans[1] & hready & clk_en;

   // Register the address phase for the data phase
   always @(posedge clock or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         ph_act_r  <= 1'b0;
         ph_wr_r   <= 1'b0;
         ph_addr_r <= 8'h00;
      end else if (clk_en) begin
         if (hready) begin
            ph_act_r  <= take;
            ph_wr_r   <= hwrite;
            ph_addr_r <= haddr[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   reg        en_r;                    // Module enable
   reg        wren_r;                  // Value write enable
   reg        oe_r;                    // Output enable
   reg [1:0]  ptr_r;                   // Window pointer
   reg [7:0]  cal_r;                   // Calibration trim
   reg        half_r;                  // Half-second status
   reg [7:0]  tf_r [0:7];              // Time fields, index {hi/lo, ptr}
   reg [31:0] rd_nxt;                  // Read mux output

   // Side effects only in the last cycle of a data phase
   wire wr_cfg  = ph_act_r & hready & ph_wr_r & (ph_addr_r == `RCW_CFG_OFS);
   wire acc_h   = ph_act_r & hready & (ph_addr_r == `RCW_VALH_OFS);
   wire acc_l   = ph_act_r & hready & (ph_addr_r == `RCW_VALL_OFS);
   wire wr_vh   = acc_h & ph_wr_r & wren_r;
   wire wr_vl   = acc_l & ph_wr_r & wren_r;
   // Seconds sit in the low byte at pointer zero
   wire wr_sec  = wr_vl & (ptr_r == `RCW_PTR_0);
   // Code 11 of the high byte holds nothing
   wire hi_resv = (ptr_r == `RCW_PTR_3);

   // Configuration register; only the power-on reset reaches it
   always @(posedge clock or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         en_r   <= 1'b0;
         wren_r <= 1'b0;
         oe_r   <= 1'b0;
         ptr_r  <= `RCW_PTR_RST;
         cal_r  <= `RCW_FIELD_RST;
      end else if (clk_en) begin
         if (wr_cfg) begin
            // Lock test uses the stored write-enable, not the new one
            if (wren_r)
               en_r <= hwdata[`RCW_EN_BIT];
            wren_r <= hwdata[`RCW_WREN_BIT];
            oe_r   <= hwdata[`RCW_OE_BIT];
            ptr_r  <= hwdata[`RCW_PTR_HI:`RCW_PTR_LO];
            cal_r  <= hwdata[7:0];
         end else if (acc_h && ptr_r != `RCW_PTR_0) begin
            ptr_r <= ptr_r - 2'b01;
         end
      end
   end

   // Half-second flag; a seconds write clears it unless a half-second edge comes in the same cycle
   always @(posedge clock or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         half_r <= 1'b0;
      end else if (clk_en) begin
         if (hs_s2_r && !hs_d_r)
            half_r <= 1'b1;
         else if (wr_sec)
            half_r <= 1'b0;
         else if (!hs_s2_r)
            half_r <= 1'b0;
      end
   end

   // Time field store behind the two windows
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_tf
         always @(posedge clock or negedge rst_s2_r) begin
            if (!rst_s2_r) begin
               tf_r[gi] <= `RCW_FIELD_RST;
            end else if (clk_en) begin
               if (gi >= 4 && wr_vh && !hi_resv && ptr_r == gi - 4)
                  tf_r[gi] <= hwdata[7:0];
               else if (gi < 4 && wr_vl && ptr_r == gi)
                  tf_r[gi] <= hwdata[7:0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read data selection
   always @* begin
      rd_nxt = 32'h0000_0000;
      if (ph_addr_r == `RCW_CFG_OFS) begin
         rd_nxt[`RCW_EN_BIT]   = en_r;
         rd_nxt[`RCW_WREN_BIT] = wren_r;
         rd_nxt[`RCW_SYNC_BIT] = rip_s2_r;
         rd_nxt[`RCW_HALF_BIT] = half_r;
         rd_nxt[`RCW_OE_BIT]   = oe_r;
         rd_nxt[`RCW_PTR_HI:`RCW_PTR_LO] = ptr_r;
         rd_nxt[7:0] = cal_r;
      end else if (ph_addr_r == `RCW_VALH_OFS) begin
         // Reserved code reads as zero
         if (!hi_resv)
            rd_nxt[7:0] = tf_r[{1'b1, ptr_r}];
      end else if (ph_addr_r == `RCW_VALL_OFS) begin
         rd_nxt[7:0] = tf_r[{1'b0, ptr_r}];
      end else if (ph_addr_r == `RCW_TIME_OFS) begin
         // Minutes/seconds pair together, seconds low
         rd_nxt[15:0] = {tf_r[4], tf_r[0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always @(posedge clock or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         hrdata        <= 32'h0000_0000;
         hreadyout     <= 1'b0;
         hresp         <= 1'b0;
         module_enable <= 1'b0;
         clock_out_en  <= 1'b0;
         calibration   <= 8'h00;
      end else if (clk_en) begin
         hresp         <= 1'b0;
         // A read stretches its data phase by one wait state
         if (take && !hwrite) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
         end else if (ph_act_r && !ph_wr_r && !hreadyout) begin
            // Word captured before the pointer steps
            hrdata    <= rd_nxt;
            hreadyout <= 1'b1;
         end else begin
            hreadyout <= 1'b1;
         end
         module_enable <= en_r;
         clock_out_en  <= oe_r & en_r;
         calibration   <= cal_r;
      end
   end

endmodule // rcw_top
`default_nettype wire

// ==== bench/rcw_top_monitor.sv ====
// Port checker for the clock config window block
`timescale 1ns/1ns
`default_nettype none
`include "rcw_regs.vh"
module rcw_top_monitor (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        clk_en,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        module_enable,
   input wire logic        clock_out_en,
   input wire logic [7:0]  calibration
);
   logic w_cfg_r;   // Config write in its data phase
   ////////////////////////////////////////////////////////////////
   // Tracks accepted config writes, the only cause of a trim or enable change
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) w_cfg_r <= 1'b0;
      else w_cfg_r <= clk_en && hsel && htrans[1] && hready && hwrite && haddr == `RCW_CFG_OFS;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_rd_unmapped;
      hsel && htrans[1] && hready && !hwrite && haddr > 32'h0000_000C
         && haddr < 32'h0000_0100;
   endsequence
   sequence s_cfg_written;
      $past(w_cfg_r) || $past(w_cfg_r, 2) || $past(w_cfg_r, 3);
   endsequence
   a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
   a_ready_held: assert property ($fell(hreadyout) |=> hreadyout) else $error("long wait");
   a_cal_cause: assert property ($changed(calibration) |-> s_cfg_written)
      else $error("calibration moved without write");
   a_en_cause: assert property ($changed(module_enable) |-> s_cfg_written)
      else $error("enable moved without write");
   a_oe_needs_en: assert property (clock_out_en |-> ##[0:2] module_enable)
      else $error("output on while disabled");
   a_upper_zero: assert property (hrdata[31:16] == 16'h0000) else $error("upper bits set");
   a_unmapped_zero: assert property (s_rd_unmapped ##1 !hready |=> hrdata == 32'h0000_0000)
      else $error("unmapped read nonzero");
   a_rst_outs: assert property (disable iff (1'b0) !resetn |-> !hreadyout && !module_enable
      && !clock_out_en && calibration == 8'h00) else $error("outputs not cleared in reset");
endmodule // rcw_top_monitor
bind rcw_top rcw_top_monitor u_mon (.clock(clock), .resetn(resetn), .clk_en(clk_en),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .module_enable(module_enable),
   .clock_out_en(clock_out_en), .calibration(calibration));
`default_nettype wire

// ==== bench/rtc_config_window_pointer_tb_top.sv ====
// Self-checking bench for the clock config window block
`timescale 1ns/1ns
`default_nettype none
`include "rcw_regs.vh"
`define CHK(a,b) begin comparisons++; if ((a)!==(b)) begin miscompares++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module rtc_config_window_pointer_tb_top;
   logic clock = 0, resetn = 1, clk_en = 1, ripple_pin = 0, half_sec_pin = 0;
   logic hsel = 0, hwrite = 0, rm = 0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = 0, hwdata = 0, ev;
   logic [31:0] q[$];   // Expected read data, oldest first
   logic [7:0]  s = 8'h17, dl[4], dh[4];
   wire  [31:0] hrdata;
   wire  [7:0]  calibration;
   wire         hreadyout, hresp, module_enable, clock_out_en;
   int miscompares = 0, comparisons = 0;
   localparam logic [31:0] CF = `RCW_CFG_OFS, VH = `RCW_VALH_OFS;
   localparam logic [31:0] VL = `RCW_VALL_OFS, TM = `RCW_TIME_OFS;
   always #20 clock = ~clock;
   rcw_top dut (.clock(clock), .resetn(resetn), .clk_en(clk_en), .ripple_pin(ripple_pin),
      .half_sec_pin(half_sec_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .module_enable(module_enable),
      .clock_out_en(clock_out_en), .calibration(calibration));
   function automatic logic [7:0] nx(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // Config word from {enable, write enable, output enable}, pointer, trim
   function automatic logic [31:0] cf(input logic [2:0] f, input logic [1:0] p,
         input logic [7:0] c);
      return {16'h0000, f[2], 1'b0, f[1], 2'b00, f[0], p, c};
   endfunction
   // One single transfer; ready is waited for, never assumed
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1; htrans <= 2'b10; haddr <= a; hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'b00; hwdata <= d; rm <= !w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rm <= 0;
   endtask
   task automatic rdc(input logic [31:0] a, e);
      q.push_back(e);
      bus(0, a, 0);
   endtask
   task automatic up();
      repeat (16) @(posedge clock);
      resetn <= 1;
      do @(posedge clock); while (hreadyout !== 1'b1);
   endtask
   // Read data taken at the edge that ends the data phase
   always @(posedge clock) begin
      if (rm && hreadyout === 1'b1) begin
         ev = q.pop_front();
         `CHK(hrdata, ev)
      end
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
   initial begin
      resetn <= 0;
      up();
      s = nx(s);
      rdc(CF, 0);
      rdc(32'h0000_0010, 0);
      bus(1, CF, cf(3'b101, 2'b00, s));
      rdc(CF, cf(3'b001, 2'b00, s));
      `CHK(module_enable, 1'b0)
      bus(1, CF, cf(3'b011, 2'b00, s));
      bus(1, CF, cf(3'b111, 2'b00, s));
      rdc(CF, cf(3'b111, 2'b00, s));
      `CHK({module_enable, clock_out_en, calibration}, {2'b11, s})
      $display("config test done");
      for (int p = 3; p >= 0; p--) begin
         s = nx(s); dl[p] = s; s = nx(s); dh[p] = s;
         bus(1, CF, cf(3'b111, 2'(p), 0));
         bus(1, VL, {24'h0000_00, dl[p]});
         bus(1, VH, {24'h0000_00, dh[p]});
      end
      for (int p = 3; p >= 0; p--) begin
         bus(1, CF, cf(3'b111, 2'(p), 0));
         rdc(VL, {24'h0000_00, dl[p]});
         rdc(VH, p == 3 ? 0 : {24'h0000_00, dh[p]});
         rdc(CF, cf(3'b111, p == 0 ? 2'b00 : 2'(p - 1), 0));
      end
      rdc(TM, {16'h0000, dh[0], dl[0]});
      bus(1, CF, cf(3'b101, 2'b00, 0));
      bus(1, VL, {24'h0000_00, ~dl[0]});
      rdc(VL, {24'h0000_00, dl[0]});
      $display("window test done");
      ripple_pin <= 1; half_sec_pin <= 1;
      repeat (4) @(posedge clock);
      rdc(CF, cf(3'b101, 2'b00, 0) | 32'h0000_1800);
      rdc(CF, cf(3'b101, 2'b00, 0) | 32'h0000_1800);
      bus(1, CF, cf(3'b111, 2'b00, 0));
      bus(1, VL, {24'h0000_00, dl[0]});
      rdc(CF, cf(3'b111, 2'b00, 0) | 32'h0000_1000);
      ripple_pin <= 0; half_sec_pin <= 0;
      repeat (4) @(posedge clock);
      rdc(CF, cf(3'b111, 2'b00, 0));
      resetn <= 0;
      up();
      rdc(CF, 0);
      repeat (3) @(posedge clock);
      $display("status and reset test done");
      complete_run();
   end
endmodule // rtc_config_window_pointer_tb_top
`default_nettype wire
